// >>> rtl/interval_clock_regs.svh
// Notes on behaviour
// - Decrement once per 10 us tick while running
// - Preset is up to three 8-bit bytes
// - Interrupt at zero only if command bit 0
// - Bit 1 restarts from preset, else hold
// - Bits 3:2 give byte count for load/readout
// - Bits 3:0 sampled only when bit 4 set
// - Bit 6 arms preset byte loading
// - Count only while latest command bit 7 set
// - Bit 5 requests a count snapshot
// - Command word latched on command transfer
// - Status bit 0 reads one: on-line
// - Preset bytes arrive most significant first
// - Unloaded high counter bytes cleared to zero
// - Answers only its fixed unit code
// - Counting ignores host run or halt
// - First period may be one tick short
// - Interrupt level routed outside, any group
// - Snapshot holds 24 bits, read MSB first
// - Zero-count interrupt ends snapshot readout
// - Auto restart reloads last preset at zero, same edge as interrupt
`ifndef INTERVAL_CLOCK_REGS_SVH
`define INTERVAL_CLOCK_REGS_SVH
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 10000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define CMD_INT_EN_BIT 0
`define CMD_RESTART_BIT 1
`define CMD_BCOUNT_LO 2
`define CMD_BCOUNT_HI 3
`define CMD_SAMPLE_BIT 4
`define CMD_SNAP_BIT 5
`define CMD_LOAD_BIT 6
`define CMD_RUN_BIT 7
`define CMD_RESET 8'h00
`define STATUS_ONLINE 8'h01
`define DEFAULT_UNIT 2'h0
`endif

// >>> rtl/interval_clock_pkg.sv
package interval_clock_pkg;
    // One channel transfer from the I/O controller
    typedef struct packed {
        logic [1:0] unit;
        logic output_command_transfer;
        logic input_status_transfer;
        logic output_data_transfer;
        logic input_data_transfer;
        logic [7:0] data;
    } chan_req_t;
    // Answer returned on an input transfer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } chan_rsp_t;
    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_LOAD = 2'b01,
        XFER_SNAP = 2'b10
    } xfer_state_t;
endpackage

// >>> rtl/tick_divider.sv
`timescale 1ns/1ns
`include "interval_clock_regs.svh"
// Free-running 10 us time base, never gated by the host
module tick_divider
(
    input wire logic sys_clk,
    input wire logic rst_sync_b,
    output logic tick
);
    localparam int CW = $clog2(`TICK_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(`TICK_CYCLES - 1);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic tick_next;

    // Wrap counter; pulse on wrap
    always_comb
    begin
        tick_next = (cnt_reg == LAST);
        cnt_next = tick_next ? '0 : cnt_reg + CW'(1);
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end

    // Pulse only at the wrap, so spacing is exactly one full count
    a_tick_wrap: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (cnt_reg == LAST) |=> tick)
        else $error("tick missing at wrap");
    a_tick_only_wrap: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        tick |-> cnt_reg == '0)
        else $error("tick away from wrap");
endmodule

// >>> rtl/io_countdown_interval_clock.sv
`timescale 1ns/1ns
`include "interval_clock_regs.svh"
module io_countdown_interval_clock
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [1:0] unit_strap,
    input wire interval_clock_pkg::chan_req_t req,
    output interval_clock_pkg::chan_rsp_t rsp,
    output logic zero_irq
);
    import interval_clock_pkg::*;

    logic rst_meta_b;
    logic rst_sync_b;
    logic tick;
    logic [1:0] strap_meta_reg;
    logic [1:0] strap_sync_reg;
    logic run_reg;
    logic run_next;
    logic [3:0] cfg_reg;
    logic [3:0] cfg_next;
    logic [23:0] count_reg;
    logic [23:0] count_next;
    logic [23:0] preset_reg;
    logic [23:0] preset_next;
    logic [23:0] snap_reg;
    logic [23:0] snap_next;
    logic [1:0] bytes_left_reg;
    logic [1:0] bytes_left_next;
    xfer_state_t xfer_reg;
    xfer_state_t xfer_next;
    chan_rsp_t rsp_next;
    logic irq_next;
    logic sel;
    logic hit_zero;
    logic data_out_sel;
    logic data_in_sel;

    // Byte count field; zero treated as three full bytes
    function automatic logic [1:0] byte_total(input logic [3:0] cfg);
        byte_total = (cfg[3:2] == 2'h0) ? 2'h3 : cfg[3:2];
    endfunction

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // Strap is static, yet still a pin, so two flops; settled long before reset ends
    always_ff @(posedge sys_clk)
    begin
        strap_meta_reg <= unit_strap;
        strap_sync_reg <= strap_meta_reg;
    end

    tick_divider u_tick
    (
        .sys_clk(sys_clk),
        .rst_sync_b(rst_sync_b),
        .tick(tick)
    );

    // Unit code from the synchronised strap
    assign sel = (req.unit == strap_sync_reg);
    assign hit_zero = run_reg && tick && (count_reg == 24'h000001);
    // Lone data strobes, as the priority chain below sees them
    assign data_out_sel = sel && req.output_data_transfer && !req.output_command_transfer && !req.input_status_transfer;
    assign data_in_sel = sel && req.input_data_transfer && !req.output_command_transfer
                         && !req.input_status_transfer && !req.output_data_transfer;

    always_comb
    begin
        run_next = run_reg;
        cfg_next = cfg_reg;
        count_next = count_reg;
        preset_next = preset_reg;
        snap_next = snap_reg;
        bytes_left_next = bytes_left_reg;
        xfer_next = xfer_reg;
        rsp_next = '0;
        irq_next = 1'b0;
        // Countdown, gated only by run bit, never by the host
        if (run_reg && tick && count_reg != 24'h0)
        begin
            count_next = count_reg - 24'h1;
            if (hit_zero)
            begin
                irq_next = cfg_reg[`CMD_INT_EN_BIT];
                if (xfer_reg == XFER_SNAP)
                begin
                    xfer_next = XFER_IDLE;
                end
                if (cfg_reg[`CMD_RESTART_BIT])
                begin
                    count_next = preset_reg;
                end
                else
                begin
                    run_next = 1'b0;
                end
            end
        end
        if (sel && req.output_command_transfer)
        begin
            // Command latch; low bits only sampled with bit 4
            run_next = req.data[`CMD_RUN_BIT];
            if (req.data[`CMD_SAMPLE_BIT])
            begin
                cfg_next = req.data[3:0];
            end
            if (req.data[`CMD_LOAD_BIT])
            begin
                xfer_next = XFER_LOAD;
                preset_next = 24'h0;
                bytes_left_next = req.data[`CMD_SAMPLE_BIT] ? byte_total(req.data[3:0]) : byte_total(cfg_reg);
            end
            else if (req.data[`CMD_SNAP_BIT])
            begin
                xfer_next = XFER_SNAP;
                snap_next = count_reg;
                bytes_left_next = req.data[`CMD_SAMPLE_BIT] ? byte_total(req.data[3:0]) : byte_total(cfg_reg);
            end
        end
        else if (sel && req.input_status_transfer)
        begin
            rsp_next.valid = 1'b1;
            rsp_next.data = `STATUS_ONLINE;
        end
        else if (sel && req.output_data_transfer && xfer_reg == XFER_LOAD)
        begin
            // Shift in MSB first; unloaded upper bytes stay zero
            preset_next = {preset_reg[15:0], req.data};
            bytes_left_next = bytes_left_reg - 2'h1;
            if (bytes_left_reg == 2'h1)
            begin
                xfer_next = XFER_IDLE;
                count_next = {preset_reg[15:0], req.data};
            end
        end
        else if (sel && req.input_data_transfer)
        begin
            rsp_next.valid = 1'b1;
            rsp_next.data = 8'h00;
            if (xfer_reg == XFER_SNAP)
            begin
                // Byte selected by how many remain, MSB first
                case (bytes_left_reg)
                    2'h3: rsp_next.data = snap_reg[23:16];
                    2'h2: rsp_next.data = snap_reg[15:8];
                    2'h1: rsp_next.data = snap_reg[7:0];
                    default: rsp_next.data = 8'h00;
                endcase
                bytes_left_next = bytes_left_reg - 2'h1;
                if (bytes_left_reg == 2'h1)
                begin
                    xfer_next = XFER_IDLE;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            run_reg <= 1'b0;
            cfg_reg <= 4'h0;
            count_reg <= 24'h0;
            preset_reg <= 24'h0;
            snap_reg <= 24'h0;
            bytes_left_reg <= 2'h0;
            xfer_reg <= XFER_IDLE;
            rsp <= '0;
            zero_irq <= 1'b0;
        end
        else
        begin
            run_reg <= run_next;
            cfg_reg <= cfg_next;
            count_reg <= count_next;
            preset_reg <= preset_next;
            snap_reg <= snap_next;
            bytes_left_reg <= bytes_left_next;
            xfer_reg <= xfer_next;
            rsp <= rsp_next;
            zero_irq <= irq_next;
        end
    end

    // Checks beside the logic
    a_irq_at_zero: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        zero_irq |-> $past(cfg_reg[`CMD_INT_EN_BIT]) && $past(count_reg) == 24'h1)
        else $error("interrupt without enable or zero");
    a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (run_reg && !tick && !req.output_command_transfer && !req.output_data_transfer) |=> $stable(count_reg))
        else $error("count moved without tick");
    a_hold_at_zero: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (hit_zero && !cfg_reg[`CMD_RESTART_BIT] && !(sel && req.output_command_transfer)) |=> !run_reg && count_reg == 24'h0)
        else $error("no hold at zero");
    a_restart_load: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (hit_zero && cfg_reg[`CMD_RESTART_BIT] && !(sel && (req.output_data_transfer || req.output_command_transfer)))
        |=> count_reg == $past(preset_reg))
        else $error("no reload on restart");
    a_status_online: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (sel && req.input_status_transfer && !req.output_command_transfer) |=> rsp.valid && rsp.data == `STATUS_ONLINE)
        else $error("status not on-line");
    a_unit_ignore: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (!sel && !hit_zero) |=> !rsp.valid && $stable(run_reg))
        else $error("answered foreign unit");
    a_run_latch: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (sel && req.output_command_transfer) |=> run_reg == $past(req.data[`CMD_RUN_BIT]))
        else $error("run bit not latched");
    a_cfg_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (sel && req.output_command_transfer && !req.data[`CMD_SAMPLE_BIT]) |=> $stable(cfg_reg))
        else $error("config changed without sample");
    a_snap_end: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (hit_zero && xfer_reg == XFER_SNAP && !(sel && req.output_command_transfer)) |=> xfer_reg == XFER_IDLE)
        else $error("snapshot not ended");

    // Command side: sampling, arming and capture
    a_cfg_sample: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (sel && req.output_command_transfer && req.data[`CMD_SAMPLE_BIT])
        |=> cfg_reg == $past(req.data[3:0]))
        else $error("config bits not sampled");
    a_load_arm: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (sel && req.output_command_transfer && req.data[`CMD_LOAD_BIT])
        |=> xfer_reg == XFER_LOAD && preset_reg == 24'h0)
        else $error("load not armed");
    a_load_bytes: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (sel && req.output_command_transfer && req.data[`CMD_LOAD_BIT] && req.data[`CMD_SAMPLE_BIT])
        |=> bytes_left_reg == byte_total($past(req.data[3:0])))
        else $error("byte count not taken");
    a_snap_take: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (sel && req.output_command_transfer && !req.data[`CMD_LOAD_BIT] && req.data[`CMD_SNAP_BIT])
        |=> xfer_reg == XFER_SNAP && snap_reg == $past(count_reg))
        else $error("snapshot not taken");

    // Preset bytes: shift in, finish, refuse strays
    a_preset_shift: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (data_out_sel && xfer_reg == XFER_LOAD)
        |=> preset_reg == {$past(preset_reg[15:0]), $past(req.data)})
        else $error("preset byte not shifted in");
    a_load_done: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (data_out_sel && xfer_reg == XFER_LOAD && bytes_left_reg == 2'h1)
        |=> xfer_reg == XFER_IDLE && count_reg == preset_reg)
        else $error("count not loaded from preset");
    a_load_ignore: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (data_out_sel && xfer_reg != XFER_LOAD) |=> $stable(preset_reg))
        else $error("stray data byte taken");
    a_preset_keep: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        !(sel && (req.output_command_transfer || req.output_data_transfer)) |=> $stable(preset_reg))
        else $error("preset changed on its own");

    // Snapshot readout, high byte first
    a_snap_high: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (data_in_sel && xfer_reg == XFER_SNAP && bytes_left_reg == 2'h3)
        |=> rsp.valid && rsp.data == $past(snap_reg[23:16]))
        else $error("wrong high snapshot byte");
    a_snap_mid: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (data_in_sel && xfer_reg == XFER_SNAP && bytes_left_reg == 2'h2)
        |=> rsp.valid && rsp.data == $past(snap_reg[15:8]))
        else $error("wrong middle snapshot byte");
    a_snap_low: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (data_in_sel && xfer_reg == XFER_SNAP && bytes_left_reg == 2'h1)
        |=> rsp.valid && rsp.data == $past(snap_reg[7:0]) && xfer_reg == XFER_IDLE)
        else $error("wrong low snapshot byte");
    a_snap_keep: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        !(sel && req.output_command_transfer) |=> $stable(snap_reg))
        else $error("snapshot changed without command");
    a_data_in_idle: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (data_in_sel && xfer_reg != XFER_SNAP) |=> rsp.valid && rsp.data == 8'h00)
        else $error("data outside snapshot not zero");

    // Counting and the zero event
    a_count_down: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (run_reg && tick && count_reg > 24'h1 && !data_out_sel) |=> count_reg == $past(count_reg) - 24'h1)
        else $error("count did not step down");
    a_hold_no_run: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (!run_reg && !data_out_sel) |=> $stable(count_reg))
        else $error("count moved while held");
    a_zero_stays: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (count_reg == 24'h0 && !data_out_sel) |=> count_reg == 24'h0 && !zero_irq)
        else $error("count left zero on its own");
    a_restart_run: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (hit_zero && cfg_reg[`CMD_RESTART_BIT] && !(sel && req.output_command_transfer)) |=> run_reg)
        else $error("restart stopped counting");
    a_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        (hit_zero && !cfg_reg[`CMD_INT_EN_BIT]) |=> !zero_irq)
        else $error("masked interrupt raised");
    a_irq_single: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        zero_irq |=> !zero_irq)
        else $error("interrupt wider than one cycle");

    c_irq: cover property (@(posedge sys_clk) disable iff (!rst_sync_b) zero_irq);
    c_load_done: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
        xfer_reg == XFER_LOAD ##1 xfer_reg == XFER_IDLE);
    c_snap_read: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
        rsp.valid && xfer_reg == XFER_SNAP);
    c_restart: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
        hit_zero && cfg_reg[`CMD_RESTART_BIT]);
    c_snap_cut: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
        hit_zero && xfer_reg == XFER_SNAP);
endmodule

// >>> tb/cpu_channel_model.sv
`timescale 1ns/1ns
// Programmed I/O channel side: one strobe per transfer, one cycle wide
module cpu_channel_model
(
    input wire logic sys_clk,
    output interval_clock_pkg::chan_req_t req,
    input wire interval_clock_pkg::chan_rsp_t rsp
);
    import interval_clock_pkg::*;
    logic [7:0] last_data = 8'h00;
    initial req = '0;
    // Kind 0 command, 1 status, 2 data out, 3 data in
    task automatic xfer(input logic [1:0] kind, input logic [1:0] unit, input logic [7:0] data,
                        output logic valid, output logic [7:0] rdata);
        @(posedge sys_clk);
        #1;
        req.unit = unit;
        req.data = data;
        req.output_command_transfer = (kind == 2'd0);
        req.input_status_transfer = (kind == 2'd1);
        req.output_data_transfer = (kind == 2'd2);
        req.input_data_transfer = (kind == 2'd3);
        last_data = data;
        @(posedge sys_clk);
        #1;
        // Released bus shows the inverse so a stale byte never looks valid
        req = '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, ~last_data};
        valid = rsp.valid;
        rdata = rsp.data;
    endtask
endmodule

// >>> tb/tb_io_countdown_interval_clock.sv
`timescale 1ns/1ns
module tb_io_countdown_interval_clock;
    import interval_clock_pkg::*;
    localparam int TICK = 1000;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    chan_req_t req;
    chan_rsp_t rsp;
    logic zero_irq;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int irq_seen = 0;
    int irq_cyc = 0;
    int t0;
    logic v;
    logic [7:0] d;
    logic [23:0] val;
    logic [23:0] a;
    logic [23:0] b;

    always #5 sys_clk = ~sys_clk;
    // Cycle stamp and log of zero-count pulses
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (zero_irq === 1'b1)
        begin
            irq_seen <= irq_seen + 1;
            irq_cyc <= cyc;
        end
    end

    io_countdown_interval_clock uut(.sys_clk(sys_clk), .rst_b(rst_b), .unit_strap(2'h2), .req(req),
                                    .rsp(rsp), .zero_irq(zero_irq));
    cpu_channel_model host(.sys_clk(sys_clk), .req(req), .rsp(rsp));

    function automatic logic [23:0] keep_bytes(input logic [23:0] x, input int n);
        return x & ((24'h1 << (8 * n)) - 24'h1);
    endfunction

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        host.xfer(2'd0, 2'h2, c, v, d);
    endtask
    // Arm loading with byte count n, then n bytes high first
    task automatic load(input logic [23:0] x, input int n);
        cmd({4'h5, n[1:0], 2'b00});
        for (int i = n - 1; i >= 0; i--)
            host.xfer(2'd2, 2'h2, x[8*i +: 8], v, d);
    endtask
    task automatic snap(input logic [7:0] c, output logic [23:0] x);
        cmd(c);
        x = 24'h0;
        for (int i = 0; i < 3; i++)
        begin
            host.xfer(2'd3, 2'h2, 8'h00, v, d);
            x = {x[15:0], d};
        end
    endtask
    // Bounded wait, one cycle late at most, so stamps come from irq_cyc
    task automatic wait_irq(input int lim);
        int start;
        start = irq_seen;
        for (int i = 0; i < lim && irq_seen == start; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic close_out();
        $display("TB: checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the roughly 16k cycles of the sequence
    initial
    begin
        #(40000 * 10);
        fails++;
        close_out();
    end

    initial
    begin
        void'($urandom(32'hbefc));
        repeat (20) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge sys_clk);
        host.xfer(2'd1, 2'h2, 8'h00, v, d);
        check({15'h0, v, d}, 24'h101, "status");
        host.xfer(2'd1, 2'h0, 8'h00, v, d);
        check({23'h0, v}, 24'h0, "foreign unit answered");
        // Each byte count, wider value first so stale high bytes would show
        for (int n = 3; n >= 1; n--)
        begin
            val = 24'($urandom);
            load(val, n);
            cmd(8'h1c);
            snap({4'h2, n[1:0], 2'b00}, a);
            check(a, keep_bytes(val, n), "preset readback");
        end
        // One-shot: three ticks, then hold at zero
        load(24'h3, 3);
        cmd(8'h9d);
        t0 = cyc;
        wait_irq(4 * TICK);
        check({23'h0, (irq_cyc - t0 >= 2 * TICK - 2) && (irq_cyc - t0 <= 3 * TICK + 4)}, 24'h1, "first period");
        t0 = irq_seen;
        repeat (2500) @(posedge sys_clk);
        check(24'(irq_seen - t0), 24'h0, "hold after zero");
        snap(8'h20, a);
        check(a, 24'h0, "held count");
        // Auto restart gives exact reload period
        load(24'h2, 3);
        cmd(8'h9f);
        wait_irq(3 * TICK);
        t0 = irq_cyc;
        wait_irq(3 * TICK);
        check({23'h0, (irq_cyc - t0 >= 2 * TICK - 2) && (irq_cyc - t0 <= 2 * TICK + 2)}, 24'h1, "reload period");
        // Snapshot cut short by the zero-count interrupt; late bytes read zero
        cmd(8'ha0);
        host.xfer(2'd3, 2'h2, 8'h00, v, d);
        wait_irq(3 * TICK);
        host.xfer(2'd3, 2'h2, 8'h00, v, d);
        check({15'h0, v, d}, 24'h100, "snapshot middle after irq");
        host.xfer(2'd3, 2'h2, 8'h00, v, d);
        check({15'h0, v, d}, 24'h100, "snapshot low after irq");
        // Interrupt disabled, still restarting; a zero in the command cycle may still fire once
        cmd(8'h9e);
        repeat (2) @(posedge sys_clk);
        t0 = irq_seen;
        repeat (3 * TICK) @(posedge sys_clk);
        check(24'(irq_seen - t0), 24'h0, "masked irq");
        // Hold first, so no tick slips between snapshot and stop; stray data out is ignored
        cmd(8'h00);
        snap(8'h20, a);
        host.xfer(2'd2, 2'h2, 8'h77, v, d);
        repeat (1500) @(posedge sys_clk);
        snap(8'h20, b);
        check(b, a, "hold count");
        close_out();
    end
endmodule
